// ---- stack_ram_store.sv ----
// Purpose: 1024 x 8 single-port store for the on-chip read/write memory
// Assumes: synchronous write, registered read
// Notes: read data holds until the next read
`timescale 1ns/1ps
`default_nettype none
module stack_ram_store #(
    parameter int unsigned DEPTH = 1024,
    parameter int unsigned AW = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // access port
    input wire logic [AW-1:0] idx,
    input wire logic we,
    input wire logic re,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_r
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (re) begin
            rdata_nxt = mem[idx];
        end
    end

    // contents carry no reset, only the read register does
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[idx] <= wdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- vector_map_and_stack_ram.sv ----
// Purpose: vector decode, priority select, stack engine and on-chip read/write memory
// Assumes: core requests are synchronous to mclk; vector bytes arrive combinationally on fetch_data
// Notes: overview of operation below
// Overview of operation
// - vectors span FFDA..FFFF, two bytes, high first
// - priority rises with vector address
// - periodic timer FFDA, link FFDC, converter FFDE
// - async serial transmit FFE0, receive FFE2, error FFE4
// - sync serial transmit FFE6, receive FFE8
// - timer overflow FFEA, channels 5..0 FFEC..FFF6
// - clock FFF8, external FFFA, software FFFC, reset FFFE
// - 1024 memory bytes at 0050..044F
// - stack pointer resets to 00FF, loadable anywhere
// - interrupt entry pushes five bytes
// - upper index byte is not stacked
// - subroutine call pushes two-byte return address
// - push decrements, pull increments stack pointer
package vector_map_pkg;
    localparam int unsigned NUM_SRC = 18;
    localparam int unsigned RAM_DEPTH = 1024;
    localparam int unsigned RAM_AW = 10;
    localparam logic [15:0] RAM_FIRST = 16'h0050;
    localparam logic [15:0] RAM_LAST = 16'h044F;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [15:0] VEC_LOWEST = 16'hFFDA;
    localparam logic [15:0] RESET_VEC = 16'hFFFE;
    localparam logic [2:0] INT_FRAME_BYTES = 3'h5;
    localparam logic [2:0] CALL_FRAME_BYTES = 3'h2;
    // source index 0 is lowest priority; index 17 is the software interrupt
    // every source owns a slot, so timer channel 0 and the clock vector stay reachable
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
        16'hFFDA, 16'hFFDC, 16'hFFDE,
        16'hFFE0, 16'hFFE2, 16'hFFE4,
        16'hFFE6, 16'hFFE8,
        16'hFFEA, 16'hFFEC, 16'hFFEE, 16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6,
        16'hFFF8, 16'hFFFA, 16'hFFFC};
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_PUSH = 4'h2,
        S_VHI = 4'h4,
        S_VLO = 4'h8
    } seq_state_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
module vector_map_and_stack_ram (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // interrupt requests: 0 periodic_interrupt_timer .. 15 clock, 16 external_interrupt_line, 17 software_interrupt
    input wire logic [17:0] irq_pending,
    input wire logic irq_enable,
    input wire logic [39:0] int_frame,
    // subroutine call and pull
    input wire logic call_req,
    input wire logic [15:0] call_ret,
    input wire logic pull_req,
    // stack pointer load
    input wire logic sp_load,
    input wire logic [15:0] sp_load_val,
    // core data access
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic ram_hit_r,
    // vector fetch
    output logic [15:0] fetch_addr_r,
    output logic fetch_rd_r,
    input wire logic [7:0] fetch_data,
    output logic [15:0] handler_r,
    output logic handler_valid_r,
    output logic [4:0] int_src_r,
    // status
    output logic [15:0] sp_r,
    output logic busy_r
);
    function automatic logic in_ram(input logic [15:0] a);
        return (a >= vector_map_pkg::RAM_FIRST) && (a <= vector_map_pkg::RAM_LAST);
    endfunction

    function automatic logic [9:0] ram_idx_of(input logic [15:0] a);
        logic [15:0] d;
        d = a - vector_map_pkg::RAM_FIRST;
        return d[9:0];
    endfunction

    function automatic logic [4:0] top_src(input logic [17:0] p);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < vector_map_pkg::NUM_SRC; i++) begin
            if (p[i]) begin
                s = 5'(i);
            end
        end
        return s;
    endfunction

    // only called with an index below NUM_SRC
    function automatic logic [15:0] vec_of(input logic [4:0] s);
        return vector_map_pkg::VEC_TABLE[s];
    endfunction

    vector_map_pkg::seq_state_t state_r, state_nxt;
    logic [15:0] sp_nxt, fetch_addr_nxt, handler_nxt;
    logic [39:0] frame_r, frame_nxt;
    logic [2:0] count_r, count_nxt;
    logic is_int_r, is_int_nxt;
    logic fetch_rd_nxt, handler_valid_nxt, busy_nxt, ram_hit_nxt;
    logic [4:0] int_src_nxt;
    logic ram_we, ram_re;
    logic [9:0] ram_idx;
    logic [7:0] ram_wd;
    logic [15:0] pull_addr;
    logic int_start;

    assign pull_addr = sp_r + 16'h0001;
    assign int_start = (state_r == vector_map_pkg::S_IDLE) && irq_enable && (irq_pending != 18'h00000);

    always_comb begin
        state_nxt = state_r;
        sp_nxt = sp_r;
        frame_nxt = frame_r;
        count_nxt = count_r;
        is_int_nxt = is_int_r;
        fetch_addr_nxt = fetch_addr_r;
        fetch_rd_nxt = 1'b0;
        handler_nxt = handler_r;
        handler_valid_nxt = 1'b0;
        int_src_nxt = int_src_r;
        ram_hit_nxt = 1'b0;
        ram_we = 1'b0;
        ram_re = 1'b0;
        ram_idx = 10'h000;
        ram_wd = 8'h00;
        case (state_r)
            vector_map_pkg::S_IDLE: begin
                if (int_start) begin
                    // frame is pcl,pch,x,a,ccr from low byte up; the upper index byte never enters it
                    frame_nxt = int_frame;
                    count_nxt = vector_map_pkg::INT_FRAME_BYTES;
                    is_int_nxt = 1'b1;
                    int_src_nxt = top_src(irq_pending);
                    fetch_addr_nxt = vec_of(top_src(irq_pending));
                    state_nxt = vector_map_pkg::S_PUSH;
                end else if (call_req) begin
                    frame_nxt = {24'h000000, call_ret};
                    count_nxt = vector_map_pkg::CALL_FRAME_BYTES;
                    is_int_nxt = 1'b0;
                    state_nxt = vector_map_pkg::S_PUSH;
                end else if (pull_req) begin
                    sp_nxt = pull_addr;
                    ram_re = in_ram(pull_addr);
                    ram_idx = ram_idx_of(pull_addr);
                    ram_hit_nxt = in_ram(pull_addr);
                end else if (sp_load) begin
                    sp_nxt = sp_load_val;
                end else if (mem_rd || mem_wr) begin
                    ram_hit_nxt = in_ram(mem_addr);
                    ram_re = mem_rd && in_ram(mem_addr);
                    ram_we = mem_wr && in_ram(mem_addr);
                    ram_idx = ram_idx_of(mem_addr);
                    ram_wd = mem_wdata;
                end
            end
            vector_map_pkg::S_PUSH: begin
                // a stack outside memory drops the byte; keeping it inside is software's job
                ram_we = in_ram(sp_r);
                ram_idx = ram_idx_of(sp_r);
                ram_wd = frame_r[7:0];
                frame_nxt = {8'h00, frame_r[39:8]};
                sp_nxt = sp_r - 16'h0001;
                count_nxt = count_r - 3'h1;
                if (count_r == 3'h1) begin
                    if (is_int_r) begin
                        fetch_rd_nxt = 1'b1;
                        state_nxt = vector_map_pkg::S_VHI;
                    end else begin
                        state_nxt = vector_map_pkg::S_IDLE;
                    end
                end
            end
            vector_map_pkg::S_VHI: begin
                handler_nxt = {fetch_data, handler_r[7:0]};
                fetch_addr_nxt = fetch_addr_r + 16'h0001;
                fetch_rd_nxt = 1'b1;
                state_nxt = vector_map_pkg::S_VLO;
            end
            vector_map_pkg::S_VLO: begin
                handler_nxt = {handler_r[15:8], fetch_data};
                handler_valid_nxt = 1'b1;
                state_nxt = vector_map_pkg::S_IDLE;
            end
            default: begin
                state_nxt = vector_map_pkg::S_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != vector_map_pkg::S_IDLE);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // leaving reset goes straight to fetching the reset vector
            state_r <= vector_map_pkg::S_VHI;
            sp_r <= vector_map_pkg::SP_RESET;
            frame_r <= 40'h0000000000;
            count_r <= 3'h0;
            is_int_r <= 1'b0;
            fetch_addr_r <= vector_map_pkg::RESET_VEC;
            fetch_rd_r <= 1'b1;
            handler_r <= 16'h0000;
            handler_valid_r <= 1'b0;
            int_src_r <= 5'h00;
            ram_hit_r <= 1'b0;
            busy_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            sp_r <= sp_nxt;
            frame_r <= frame_nxt;
            count_r <= count_nxt;
            is_int_r <= is_int_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            fetch_rd_r <= fetch_rd_nxt;
            handler_r <= handler_nxt;
            handler_valid_r <= handler_valid_nxt;
            int_src_r <= int_src_nxt;
            ram_hit_r <= ram_hit_nxt;
            busy_r <= busy_nxt;
        end
    end

    stack_ram_store #(
        .DEPTH(vector_map_pkg::RAM_DEPTH),
        .AW(vector_map_pkg::RAM_AW)
    ) u_store (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .idx(ram_idx),
        .we(ram_we),
        .re(ram_re),
        .wdata(ram_wd),
        .rdata_r(mem_rdata)
    );

    a_sp_reset_value: assert property (@(posedge mclk) $past(sys_rst) && !sys_rst |-> sp_r == 16'h00FF)
        else $error("stack pointer not at reset value after reset");
    a_reset_vec_first: assert property (@(posedge mclk) $past(sys_rst) && !sys_rst |->
        fetch_addr_r == 16'hFFFE && state_r == vector_map_pkg::S_VHI)
        else $error("reset vector not fetched first");
    a_push_dec_sp: assert property (@(posedge mclk) disable iff (sys_rst)
        state_r == vector_map_pkg::S_PUSH |=> sp_r == $past(sp_r) - 16'h0001)
        else $error("push did not decrement stack pointer");
    a_pull_inc_sp: assert property (@(posedge mclk) disable iff (sys_rst)
        state_r == vector_map_pkg::S_IDLE && !int_start && !call_req && pull_req
        |=> sp_r == $past(sp_r) + 16'h0001)
        else $error("pull did not increment stack pointer");
    a_int_five_bytes: assert property (@(posedge mclk) disable iff (sys_rst)
        int_start |=> state_r == vector_map_pkg::S_PUSH [*5] ##1
        (state_r == vector_map_pkg::S_VHI && sp_r == $past(sp_r, 6) - 16'h0005))
        else $error("interrupt entry did not push five bytes");
    a_call_two_bytes: assert property (@(posedge mclk) disable iff (sys_rst)
        state_r == vector_map_pkg::S_IDLE && !int_start && call_req
        |=> ##2 state_r == vector_map_pkg::S_IDLE && sp_r == $past(sp_r, 3) - 16'h0002)
        else $error("call did not push two bytes");
    a_vec_prio_pick: assert property (@(posedge mclk) disable iff (sys_rst)
        int_start |=> ##5 fetch_addr_r == vector_map_pkg::VEC_LOWEST + {10'h000, int_src_r, 1'b0} &&
        ($past(irq_pending, 6) >> int_src_r) == 18'h00001)
        else $error("vector of highest pending source not fetched");
    a_vec_hi_lo: assert property (@(posedge mclk) disable iff (sys_rst)
        state_r == vector_map_pkg::S_VHI |=> state_r == vector_map_pkg::S_VLO &&
        fetch_addr_r == $past(fetch_addr_r) + 16'h0001 ##1 handler_valid_r)
        else $error("vector bytes not read high then low");
    a_ram_window: assert property (@(posedge mclk) disable iff (sys_rst)
        state_r == vector_map_pkg::S_IDLE && !int_start && !call_req && !pull_req && !sp_load && mem_rd
        |=> ram_hit_r == (($past(mem_addr) >= 16'h0050) && ($past(mem_addr) <= 16'h044F)))
        else $error("memory decode window wrong");
    c_int_entry: cover property (@(posedge mclk) disable iff (sys_rst) int_start ##6 handler_valid_r);
    c_call_push: cover property (@(posedge mclk) disable iff (sys_rst)
        state_r == vector_map_pkg::S_IDLE && !int_start && call_req);
    c_soft_wins: cover property (@(posedge mclk) disable iff (sys_rst) int_start && irq_pending[17] && irq_pending[0]);
    c_ram_read: cover property (@(posedge mclk) disable iff (sys_rst) ram_hit_r);
endmodule
`default_nettype wire

// ---- vector_source_model.sv ----
// Purpose: far-side vector store feeding fetch_data during vector fetches
// Assumes: byte at address a is a[7:0] xor A5, answered in the same cycle
// Notes: outside a fetch the bus is not selected and shows a toggling pattern
`timescale 1ns/1ps
`default_nettype none
module vector_source_model (
    // clock
    input wire logic mclk,
    // fetch port
    input wire logic [15:0] fetch_addr_r,
    input wire logic fetch_rd_r,
    output logic [7:0] fetch_data
);
    logic tog_r = 1'b0;
    always @(posedge mclk) tog_r <= ~tog_r;
    // each address holds its own byte, so high and low halves differ
    always_comb begin
        if (fetch_rd_r) begin
            fetch_data = fetch_addr_r[7:0] ^ 8'hA5;
        end else begin
            fetch_data = {8{tog_r}} ^ 8'h3C;
        end
    end
endmodule
`default_nettype wire

// ---- vector_map_and_stack_ram_tb.sv ----
// Purpose: self-checking bench for vector decode, stack engine and memory
// Assumes: requests are made only while busy_r is low
// Notes: vector bytes come from vector_source_model
`timescale 1ns/1ps
`default_nettype none
module vector_map_and_stack_ram_tb;
    logic mclk = 1'b0, sys_rst = 1'b1, irq_enable = 1'b0;
    logic [17:0] irq_pending = '0;
    logic [15:0] call_ret = '0, sp_load_val = '0, mem_addr = '0;
    logic [39:0] int_frame = '0;
    logic call_req = 1'b0, pull_req = 1'b0, sp_load = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0;
    logic [7:0] mem_wdata = '0, mem_rdata, fetch_data;
    logic ram_hit_r, fetch_rd_r, handler_valid_r, busy_r;
    logic [15:0] fetch_addr_r, handler_r, sp_r;
    logic [4:0] int_src_r;
    int fail_count = 0, checks = 0;
    vector_map_and_stack_ram i_dut (.mclk(mclk), .sys_rst(sys_rst), .irq_pending(irq_pending),
        .irq_enable(irq_enable), .int_frame(int_frame), .call_req(call_req), .call_ret(call_ret),
        .pull_req(pull_req), .sp_load(sp_load), .sp_load_val(sp_load_val), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .ram_hit_r(ram_hit_r), .fetch_addr_r(fetch_addr_r), .fetch_rd_r(fetch_rd_r),
        .fetch_data(fetch_data), .handler_r(handler_r), .handler_valid_r(handler_valid_r),
        .int_src_r(int_src_r), .sp_r(sp_r), .busy_r(busy_r));
    vector_source_model i_vec (.mclk(mclk), .fetch_addr_r(fetch_addr_r), .fetch_rd_r(fetch_rd_r),
        .fetch_data(fetch_data));
    initial begin
        forever #2 mclk = ~mclk;
    end
    function automatic logic [15:0] hval(input logic [15:0] v);
        logic [15:0] w;
        w = v + 16'h0001;
        return {v[7:0] ^ 8'hA5, w[7:0] ^ 8'hA5};
    endfunction
    // vectors are two bytes apart from the lowest slot up to the software interrupt
    function automatic logic [15:0] vec(input logic [4:0] i);
        return 16'hFFDA + {10'h000, i, 1'b0};
    endfunction
    task automatic final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
        end
    endtask
    task automatic timeout(input string msg);
        fail_count++;
        $display("MISMATCH t=%0t timeout %s", $time, msg);
        final_report();
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_r !== 1'b0) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 20) timeout("idle");
        end
    endtask
    // k: 0 call, 1 pull, 2 stack pointer load, 3 read, 4 write; sampled one edge later
    task automatic pulse(input int k);
        @(posedge mclk);
        case (k)
            0: call_req <= 1'b1;
            1: pull_req <= 1'b1;
            2: sp_load <= 1'b1;
            3: mem_rd <= 1'b1;
            default: mem_wr <= 1'b1;
        endcase
        @(posedge mclk);
        {call_req, pull_req, sp_load, mem_rd, mem_wr} <= '0;
        #1;
    endtask
    task automatic set_sp(input logic [15:0] v);
        sp_load_val <= v;
        pulse(2);
        check(sp_r, v, "stack pointer load");
    endtask
    task automatic pull_expect(input logic [7:0] b, input logic [15:0] s);
        pull_req <= 1'b0;
        pulse(1);
        check({8'h00, mem_rdata}, {8'h00, b}, "pulled byte");
        check(sp_r, s, "sp after pull");
    endtask
    task automatic reset_fetch();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (handler_valid_r !== 1'b1 && n < 10);
        if (n >= 10) timeout("reset fetch");
        check(handler_r, hval(16'hFFFE), "reset vector");
        check(sp_r, 16'h00FF, "sp reset value");
        wait_idle();
    endtask
    task automatic irq(input logic [17:0] pend, input logic [4:0] idx, input logic [15:0] s0);
        logic [15:0] fa;
        int n;
        set_sp(s0);
        fa = '0;
        n = 0;
        @(posedge mclk);
        irq_pending <= pend;
        irq_enable <= 1'b1;
        @(posedge mclk);
        irq_pending <= '0;
        do begin
            @(posedge mclk);
            #1;
            n++;
            if (fetch_rd_r === 1'b1 && fa == 16'h0000) fa = fetch_addr_r;
        end while (handler_valid_r !== 1'b1 && n < 20);
        if (n >= 20) timeout("handler");
        check(fa, vec(idx), "vector address");
        check(handler_r, hval(vec(idx)), "handler high then low");
        check({11'h000, int_src_r}, {11'h000, idx}, "served source");
        check(sp_r, s0 - 16'h0005, "five bytes stacked");
        check(n[15:0], 16'h0007, "entry length");
        wait_idle();
    endtask
    task automatic mem_access(input logic [15:0] a, input logic [7:0] d, input bit wr);
        mem_addr <= a;
        mem_wdata <= d;
        pulse(wr ? 4 : 3);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        reset_fetch();
        // stack kept inside memory throughout, as software must
        for (int i = 0; i < 18; i++) irq(18'h00001 << i, i[4:0], 16'h0440);
        irq(18'h00209, 5'h09, 16'h0440);
        irq(18'h0C001, 5'h0F, 16'h0440);
        irq(18'h30001, 5'h11, 16'h0440);
        // disabled entry must leave the engine idle
        @(posedge mclk);
        irq_enable <= 1'b0;
        irq_pending <= 18'h00010;
        repeat (3) @(posedge mclk);
        #1;
        check({15'h0000, busy_r}, 16'h0000, "no entry while disabled");
        irq_pending <= '0;
        int_frame <= 40'h0504030201;
        irq(18'h00004, 5'h02, 16'h0300);
        for (int i = 5; i >= 1; i--) pull_expect(i[7:0], 16'h0300 - i[15:0] + 16'h0001);
        set_sp(16'h0200);
        call_ret <= 16'h1234;
        pulse(0);
        wait_idle();
        check(sp_r, 16'h01FE, "two bytes on call");
        pull_expect(8'h12, 16'h01FF);
        pull_expect(8'h34, 16'h0200);
        mem_access(16'h0050, 8'h5A, 1'b1);
        mem_access(16'h044F, 8'hC3, 1'b1);
        mem_access(16'h0450, 8'h22, 1'b1);
        mem_access(16'h0050, 8'h00, 1'b0);
        check({7'h00, ram_hit_r, mem_rdata}, 16'h015A, "first memory byte");
        mem_access(16'h044F, 8'h00, 1'b0);
        check({7'h00, ram_hit_r, mem_rdata}, 16'h01C3, "last memory byte");
        mem_access(16'h0450, 8'h00, 1'b0);
        check({7'h00, ram_hit_r, mem_rdata}, 16'h00C3, "above memory");
        mem_access(16'h004F, 8'h00, 1'b0);
        check({7'h00, ram_hit_r, mem_rdata}, 16'h00C3, "below memory");
        // a reset in mid-run must bring the stack pointer home and fetch the reset vector again
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        reset_fetch();
        final_report();
    end
endmodule
`default_nettype wire
